/* rtl/flash_program_erase_control.sv */
// Flash program/erase control: APB register file, keyed commits, command
// gating, toggle-style polling, RAM code remap and vector relocation.
// Assumes an external flash macro that accepts one operation pulse and
// holds flash_busy high until done, and a CPU bridge acting as APB master.
//
// Contract
// (R1) Host spaces command-sequence writes at least three machine cycles apart.
// (R2) Writes two cycles apart or 16 bits wide may break the sequence.
// (R3) Host waits three machine cycles after the last write before polling.
// (R4) Busy flash reads differ each time; two equal reads mean done.
// (R5) Mode 0y101 plus area, committed by key 0xD5, enables sequences.
// (R6) Mode 0y010, area 0y00, committed, blocks sequences and restores mapping.
// (R7) Both remap bits set then key 0xD4 map RAM code and vectors.
// (R8) Both remap bits cleared then key 0xD4 undo RAM mapping.
// (R9) RAM vectors: undefined/software at 0x01F8, watchdog at 0x01FC.
// (R10) Host disables interrupts and moves routine and vectors to RAM first.
// (R11) Vector reads from flash are invalid while an operation runs.
// (R12) Writing 0x10 to system control two issues a system clock reset.
// (R13) Third write 0xA0 to command address, fourth write data to target.
// (R14) Host programs only a previously erased area selected by area field.
// (R15) Host installs maskable vectors in RAM before using them there.
// (R16) First and second writes go to 0xF555 and 0xFAAA.
// (R17) Sequence writes are ignored unless committed mode is the enable value.
`timescale 1ns/1ps
module flash_program_erase_control
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [flash_ctl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash macro
	output logic flash_op_valid,
	output flash_ctl_pkg::flash_op_s flash_op,
	input wire logic flash_busy,
	input wire logic [7:0] flash_rdata,
	output logic [flash_ctl_pkg::FLASH_ADDR_W-1:0] flash_raddr,
	// Vector fetch
	input wire flash_ctl_pkg::vector_kind_e vector_kind,
	input wire logic vector_fetch,
	output logic [15:0] vector_addr,
	output logic vector_fetch_invalid,
	// System
	output logic ram_code_map,
	output logic vector_in_ram,
	output logic sysclk_reset
);

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic reg_hit(input logic [flash_ctl_pkg::ADDR_W-1:0] a,
		input logic [11:0] ofs);
		reg_hit = !a[flash_ctl_pkg::WINDOW_BIT]
			&& (a[flash_ctl_pkg::REG_OFS_W-1:0] == ofs)
			&& (a[flash_ctl_pkg::WINDOW_BIT-1:flash_ctl_pkg::REG_OFS_W] == '0);
	endfunction : reg_hit

	function automatic logic [15:0] ram_vector(input flash_ctl_pkg::vector_kind_e k,
		input logic in_ram);
		logic [15:0] base;
		base = in_ram ? flash_ctl_pkg::RAM_VEC_UNDEF_SWI : flash_ctl_pkg::FLASH_VEC_UNDEF_SWI;
		if (k == flash_ctl_pkg::VEC_WDT)
			base = in_ram ? flash_ctl_pkg::RAM_VEC_WDT : flash_ctl_pkg::FLASH_VEC_WDT;
		ram_vector = base;
	endfunction : ram_vector

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] mode_area_shadow;
	flash_ctl_pkg::flash_cfg_s cfg;
	logic [7:0] remap_shadow;
	logic toggle;
	logic [7:0] rd_data;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire in_window = paddr[flash_ctl_pkg::WINDOW_BIT];
	wire hit_mode = reg_hit(paddr, flash_ctl_pkg::OFS_MODE_AREA);
	wire hit_commit = reg_hit(paddr, flash_ctl_pkg::OFS_COMMIT_KEY);
	wire hit_sys2 = reg_hit(paddr, flash_ctl_pkg::OFS_SYS_CTRL_TWO);
	wire hit_remap = reg_hit(paddr, flash_ctl_pkg::OFS_REMAP_CTRL);
	wire hit_syskey = reg_hit(paddr, flash_ctl_pkg::OFS_SYS_KEY);
	wire hit_status = reg_hit(paddr, flash_ctl_pkg::OFS_STATUS);
	wire mapped = in_window || hit_mode || hit_commit || hit_sys2 || hit_remap
		|| hit_syskey || (hit_status && !pwrite);
	wire wr_done = access && pwrite && mapped;
	wire rd_done = access && !pwrite && mapped;
	wire [7:0] wbyte = pwdata[7:0];
	// Byte lane 0 is not checked; any strobe above it marks a wide transfer
	wire wide_write = |pstrb[3:1];

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// ----------------------------------------
	// Keyed commits
	// ----------------------------------------
	wire flash_commit = wr_done && hit_commit && wbyte == flash_ctl_pkg::FLASH_COMMIT_KEY;
	wire sys_commit = wr_done && hit_syskey && wbyte == flash_ctl_pkg::SYSTEM_KEY;
	wire cmd_enabled = (cfg.mode == flash_ctl_pkg::MODE_ENABLE); // R5 R17
	wire flash_write = wr_done && in_window;
	wire flash_read = rd_done && in_window;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_area_shadow <= flash_ctl_pkg::MODE_AREA_RESET;
		else if (wr_done && hit_mode)
			mode_area_shadow <= wbyte;
	end

	// Shadow only reaches the decoder on the keyed commit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg.mode <= flash_ctl_pkg::MODE_DISABLE;
			cfg.area <= flash_ctl_pkg::AREA_DEFAULT;
			cfg.bank <= 1'b0;
		end
		else if (flash_commit) // R5 R6
		begin
			cfg.mode <= mode_area_shadow[flash_ctl_pkg::MODE_MSB:flash_ctl_pkg::MODE_LSB];
			cfg.area <= mode_area_shadow[flash_ctl_pkg::AREA_MSB:flash_ctl_pkg::AREA_LSB];
			cfg.bank <= mode_area_shadow[flash_ctl_pkg::BANK_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			remap_shadow <= flash_ctl_pkg::REMAP_RESET;
		else if (wr_done && hit_remap)
			remap_shadow <= wbyte;
	end

	// Each bit follows its shadow on the key, so mixed settings also apply
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ram_code_map <= 1'b0;
			vector_in_ram <= 1'b0;
		end
		else if (sys_commit) // R7 R8
		begin
			ram_code_map <= remap_shadow[flash_ctl_pkg::RAM_AREA_BIT];
			vector_in_ram <= remap_shadow[flash_ctl_pkg::VEC_SEL_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sysclk_reset <= 1'b0;
		else
			sysclk_reset <= wr_done && hit_sys2
				&& wbyte == flash_ctl_pkg::SYSCLK_RESET_CODE; // R12
	end

	// ----------------------------------------
	// Command sequences
	// ----------------------------------------
	flash_cmd_decoder u_decoder
	(
		.pclk(pclk),
		.presetn(presetn),
		.wr_stb(flash_write),
		.wide_write(wide_write),
		.wr_addr(paddr[15:0]),
		.wr_data(wbyte),
		.cfg(cfg),
		.enabled(cmd_enabled),
		.busy(flash_busy),
		.op_valid(flash_op_valid),
		.op(flash_op)
	);

	// ----------------------------------------
	// Toggle polling
	// ----------------------------------------
	// Flips on every completed flash read while busy, so two reads differ
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			toggle <= 1'b0;
		else if (flash_read && flash_busy)
			toggle <= !toggle; // R4
	end

	wire [7:0] polled = flash_busy
		? {flash_rdata[7], toggle, flash_rdata[5:0]} // R4
		: flash_rdata;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	wire [7:0] status_byte = {2'h0, cfg.mode, flash_busy, vector_in_ram, ram_code_map};
	wire [7:0] reg_byte = hit_mode ? mode_area_shadow
		: hit_remap ? remap_shadow
		: hit_status ? status_byte
		: 8'h00;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data <= 8'h00;
		else if (setup)
			rd_data <= in_window ? polled : reg_byte;
	end

	assign prdata = {24'h000000, rd_data};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flash_raddr <= '0;
		else if (psel && in_window)
			flash_raddr <= {cfg.bank, cfg.area, paddr[15:0]};
	end

	// ----------------------------------------
	// Vector fetch
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			vector_addr <= flash_ctl_pkg::FLASH_VEC_UNDEF_SWI;
		else if (vector_fetch)
			vector_addr <= ram_vector(vector_kind, vector_in_ram); // R9
	end

	// Flash vectors cannot be read while the array is being altered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			vector_fetch_invalid <= 1'b0;
		else
			vector_fetch_invalid <= vector_fetch && flash_busy && !vector_in_ram; // R11
	end

endmodule : flash_program_erase_control

/* rtl/flash_ctl_pkg.sv */
// Constants, enums and carriers shared by the flash program/erase controller.
// Assumes one 50 MHz clock; one machine cycle is taken as one pclk cycle.
package flash_ctl_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_MODE_AREA = 12'h000;
	localparam logic [11:0] OFS_COMMIT_KEY = 12'h004;
	localparam logic [11:0] OFS_SYS_CTRL_TWO = 12'h008;
	localparam logic [11:0] OFS_REMAP_CTRL = 12'h00C;
	localparam logic [11:0] OFS_SYS_KEY = 12'h010;
	localparam logic [11:0] OFS_STATUS = 12'h014;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 17;
	localparam int FLASH_ADDR_W = 19;
	localparam int WINDOW_BIT = 16;
	localparam int REG_OFS_W = 12;

	// ----------------------------------------
	// Field layouts and key values
	// ----------------------------------------
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 5;
	localparam int AREA_MSB = 3;
	localparam int AREA_LSB = 2;
	localparam int BANK_BIT = 1;
	localparam int RAM_AREA_BIT = 2;
	localparam int VEC_SEL_BIT = 1;
	localparam int TOGGLE_BIT = 6;
	localparam logic [2:0] MODE_ENABLE = 3'h5;
	localparam logic [2:0] MODE_DISABLE = 3'h2;
	localparam logic [1:0] AREA_DEFAULT = 2'h0;
	localparam logic [7:0] MODE_AREA_RESET = 8'h40;
	localparam logic [7:0] REMAP_RESET = 8'h00;
	localparam logic [7:0] FLASH_COMMIT_KEY = 8'hD5;
	localparam logic [7:0] SYSTEM_KEY = 8'hD4;
	localparam logic [7:0] SYSCLK_RESET_CODE = 8'h10;

	// ----------------------------------------
	// Command sequence
	// ----------------------------------------
	localparam logic [15:0] CMD_ADDR_FIRST = 16'hF555;
	localparam logic [15:0] CMD_ADDR_SECOND = 16'hFAAA;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [3:0] MIN_WRITE_GAP = 4'h3;
	localparam logic [3:0] GAP_SAT = 4'hF;

	// ----------------------------------------
	// Vector addresses
	// ----------------------------------------
	localparam logic [15:0] RAM_VEC_UNDEF_SWI = 16'h01F8;
	localparam logic [15:0] RAM_VEC_WDT = 16'h01FC;
	localparam logic [15:0] FLASH_VEC_UNDEF_SWI = 16'hFFF8;
	localparam logic [15:0] FLASH_VEC_WDT = 16'hFFFC;

	typedef enum logic [1:0] {VEC_UNDEF, VEC_SWI, VEC_WDT, VEC_OTHER} vector_kind_e;
	typedef enum logic {OP_PROGRAM, OP_ERASE} flash_op_e;

	typedef struct packed {
		flash_op_e kind;
		logic [FLASH_ADDR_W-1:0] addr;
		logic [7:0] data;
	} flash_op_s;

	typedef struct packed {
		logic [2:0] mode;
		logic [1:0] area;
		logic bank;
	} flash_cfg_s;

endpackage : flash_ctl_pkg

/* rtl/flash_cmd_decoder.sv */
// Flash command-sequence decoder: recognises the four-write program and
// sector-erase sequences and emits one operation pulse per sequence.
// Assumes write strobes are one-cycle pulses from the APB slave.
`timescale 1ns/1ps
module flash_cmd_decoder
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Write strobe from the bus
	input wire logic wr_stb,
	input wire logic wide_write,
	input wire logic [15:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire flash_ctl_pkg::flash_cfg_s cfg,
	input wire logic enabled,
	input wire logic busy,
	// Decoded operation
	output logic op_valid,
	output flash_ctl_pkg::flash_op_s op
);

	typedef enum logic [2:0] {SEQ_IDLE, SEQ_GOT1, SEQ_GOT2, SEQ_PROG_ARM, SEQ_ERASE_ARM}
		seq_state_e;

	seq_state_e state;
	seq_state_e next_state;
	logic [3:0] gap;
	logic go;

	wire gap_short = (gap < flash_ctl_pkg::MIN_WRITE_GAP);
	// Close or wide writes abort the sequence rather than risk a wrong operation
	wire bad_write = wr_stb && (gap_short || wide_write || !enabled || busy); // R2 R17
	assign go = wr_stb && !bad_write;
	wire at_first = (wr_addr == flash_ctl_pkg::CMD_ADDR_FIRST);
	wire at_second = (wr_addr == flash_ctl_pkg::CMD_ADDR_SECOND);
	wire fire = go && (state == SEQ_PROG_ARM || (state == SEQ_ERASE_ARM
		&& wr_data == flash_ctl_pkg::CMD_SECTOR_ERASE));

	always_comb
	begin
		next_state = state;
		if (bad_write)
			next_state = SEQ_IDLE;
		else if (go)
		begin
			case (state)
				SEQ_IDLE: next_state = at_first ? SEQ_GOT1 : SEQ_IDLE;
				SEQ_GOT1: next_state = at_second ? SEQ_GOT2 : SEQ_IDLE;
				SEQ_GOT2:
				begin
					if (at_first && wr_data == flash_ctl_pkg::CMD_PROGRAM) // R13
						next_state = SEQ_PROG_ARM;
					else if (at_first && wr_data == flash_ctl_pkg::CMD_ERASE_SETUP)
						next_state = SEQ_ERASE_ARM;
					else
						next_state = SEQ_IDLE;
				end
				default: next_state = SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= SEQ_IDLE;
			gap <= flash_ctl_pkg::GAP_SAT;
			op_valid <= 1'b0;
			op <= '0;
		end
		else
		begin
			state <= next_state;
			gap <= wr_stb ? 4'h0 : ((gap == flash_ctl_pkg::GAP_SAT) ? gap : gap + 4'h1);
			op_valid <= fire;
			if (fire)
			begin
				op.kind <= (state == SEQ_PROG_ARM) ? flash_ctl_pkg::OP_PROGRAM
					: flash_ctl_pkg::OP_ERASE;
				op.addr <= {cfg.bank, cfg.area, wr_addr}; // R13
				op.data <= wr_data;
			end
		end
	end

endmodule : flash_cmd_decoder

/* tb/flash_ctl_assertions.sv */
// Port assertions for the flash program/erase controller.
// Assumes the package is compiled first; bound below.
`timescale 1ns/1ps
module flash_ctl_assertions
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [16:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Watched outputs and causes
	input wire logic flash_op_valid,
	input wire logic flash_busy,
	input wire flash_ctl_pkg::vector_kind_e vector_kind,
	input wire logic vector_fetch,
	input wire logic [15:0] vector_addr,
	input wire logic vector_fetch_invalid,
	input wire logic ram_code_map,
	input wire logic vector_in_ram,
	input wire logic sysclk_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite;
	wire key_wr = wr && paddr == 17'h00010 && pwdata[7:0] == 8'hD4;
	wire rst_wr = wr && paddr == 17'h00008 && pwdata[7:0] == 8'h10;
	wire vram = vector_fetch && vector_in_ram;
	wire is_wdt = vector_kind == flash_ctl_pkg::VEC_WDT;
	wire is_swi = vector_kind == flash_ctl_pkg::VEC_SWI;

	property p_rst; rst_wr |=> sysclk_reset ##1 !sysclk_reset; endproperty
	a_rst: assert property (p_rst) else $error("clock reset pulse wrong");
	property p_rst_cause; sysclk_reset |-> $past(rst_wr); endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("stray clock reset");
	property p_op_cause; flash_op_valid |-> $past(wr && paddr[16]); endproperty
	a_op_cause: assert property (p_op_cause) else $error("op without write");
	property p_op_pulse; flash_op_valid |=> !flash_op_valid; endproperty
	a_op_pulse: assert property (p_op_pulse) else $error("op pulse too long");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("ready low");
	property p_vwdt; vram && is_wdt |=> vector_addr == 16'h01FC; endproperty
	a_vwdt: assert property (p_vwdt) else $error("watchdog vector wrong");
	property p_vswi; vram && !is_wdt && vector_kind != 2'h3 |=> vector_addr == 16'h01F8;
	endproperty
	a_vswi: assert property (p_vswi) else $error("undef/swi vector wrong");
	property p_vbad; vector_fetch && flash_busy && !vector_in_ram |=> vector_fetch_invalid;
	endproperty
	a_vbad: assert property (p_vbad) else $error("busy fetch not flagged");
	property p_map; !$stable({ram_code_map, vector_in_ram}) |-> $past(key_wr); endproperty
	a_map: assert property (p_map) else $error("remap without key");
	c_op: cover property (flash_op_valid);
	c_map: cover property ($rose(ram_code_map));
	c_swi: cover property (vram && is_swi);
endmodule : flash_ctl_assertions

bind flash_program_erase_control flash_ctl_assertions u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .flash_op_valid, .flash_busy,
	.vector_kind, .vector_fetch, .vector_addr, .vector_fetch_invalid, .ram_code_map,
	.vector_in_ram, .sysclk_reset);

/* tb/flash_macro_model.sv */
// Behavioural flash array: busy for a fixed time per operation.
// Assumes one operation pulse at a time.
`timescale 1ns/1ps
module flash_macro_model
#(
	parameter int BUSY_CYC = 24
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Controller side
	input wire logic flash_op_valid,
	input wire logic [18:0] flash_raddr,
	output logic flash_busy,
	output logic [7:0] flash_rdata
);
	logic [7:0] cnt;
	// Data is a fixed function of address
	assign flash_rdata = flash_raddr[7:0] ^ 8'h5A;
	assign flash_busy = cnt != 8'h00;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= 8'h00;
		else if (flash_op_valid)
			cnt <= BUSY_CYC[7:0];
		else if (flash_busy)
			cnt <= cnt - 8'h01;
	end
endmodule : flash_macro_model

/* tb/tb.sv */
// Testbench for the flash program/erase controller.
// Assumes the package, design, model and checker are compiled.
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [16:0] paddr = 17'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h1;
	logic vector_fetch = 1'b0;
	flash_ctl_pkg::vector_kind_e vector_kind = flash_ctl_pkg::VEC_OTHER;
	logic [31:0] prdata;
	logic pready, pslverr, flash_op_valid, flash_busy, vector_fetch_invalid;
	logic ram_code_map, vector_in_ram, sysclk_reset;
	logic [7:0] flash_rdata, rdat, a;
	logic [18:0] flash_raddr;
	logic [15:0] vector_addr;
	logic rerr;
	flash_ctl_pkg::flash_op_s flash_op, last_op;
	int mismatches = 0;
	int n_checks = 0;
	int n_ops = 0;
	int n_rst = 0;
	int n0;

	flash_program_erase_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .flash_op_valid, .flash_op, .flash_busy,
		.flash_rdata, .flash_raddr, .vector_kind, .vector_fetch, .vector_addr,
		.vector_fetch_invalid, .ram_code_map, .vector_in_ram, .sysclk_reset);
	flash_macro_model flash (.pclk, .presetn, .flash_op_valid, .flash_raddr, .flash_busy,
		.flash_rdata);

	always #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		n_ops <= n_ops + (flash_op_valid === 1'b1);
		n_rst <= n_rst + (sysclk_reset === 1'b1);
		if (flash_op_valid === 1'b1)
			last_op <= flash_op;
	end

	// --------
	// Helpers
	// --------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic apb(input logic w, input logic [16:0] ad, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h000000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n == 16)
		begin
			mismatches++;
			end_sim();
		end
		rdat = prdata[7:0];
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	task automatic vf(input flash_ctl_pkg::vector_kind_e k);
		@(posedge pclk);
		vector_fetch <= 1'b1;
		vector_kind <= k;
		@(posedge pclk);
		vector_fetch <= 1'b0;
		#1;
	endtask : vf

	// Command writes spaced four cycles apart, then three idle cycles
	task automatic seq(input logic [7:0] c, input logic [15:0] t, input logic [7:0] d,
		input logic [3:0] s);
		n0 = n_ops;
		apb(1'b1, 17'h1F555, 8'hAA, 4'h1);
		repeat (2) @(posedge pclk);
		apb(1'b1, 17'h1FAAA, 8'h55, 4'h1);
		repeat (2) @(posedge pclk);
		apb(1'b1, 17'h1F555, c, 4'h1);
		repeat (2) @(posedge pclk);
		apb(1'b1, {1'b1, t}, d, s);
		repeat (3) @(posedge pclk);
	endtask : seq

	task automatic poll;
		int n;
		n = 0;
		do
		begin
			apb(1'b0, 17'h1E500, 8'h00, 4'h1);
			a = rdat;
			apb(1'b0, 17'h1E500, 8'h00, 4'h1);
			n++;
		end
		while (a !== rdat && n < 30);
		chk("poll_done", {flash_busy, rdat}, {1'b0, 8'h5A});
	endtask : poll

	// --------
	// Scenarios
	// --------
	task automatic t_regs;
		apb(1'b0, 17'h00000, 8'h00, 4'h1);
		chk("mode_area", rdat, 8'h40);
		apb(1'b0, 17'h00014, 8'h00, 4'h1);
		chk("status", rdat, 8'h10);
		apb(1'b1, 17'h00014, 8'hFF, 4'h1);
		chk("ro_err", rerr, 1'b1);
		apb(1'b0, 17'h00020, 8'h00, 4'h1);
		chk("unmapped", {rerr, rdat}, 9'h100);
		$display("test regs done");
	endtask : t_regs

	task automatic t_remap;
		apb(1'b1, 17'h0000C, 8'h06, 4'h1);
		chk("map_early", {ram_code_map, vector_in_ram}, 2'b00);
		apb(1'b1, 17'h00010, 8'hD4, 4'h1);
		chk("map_on", {ram_code_map, vector_in_ram}, 2'b11);
		vf(flash_ctl_pkg::VEC_WDT);
		chk("vec_wdt", vector_addr, 16'h01FC);
		vf(flash_ctl_pkg::VEC_SWI);
		chk("vec_swi", vector_addr, 16'h01F8);
		vf(flash_ctl_pkg::VEC_UNDEF);
		chk("vec_undef", vector_addr, 16'h01F8);
		apb(1'b1, 17'h0000C, 8'h00, 4'h1);
		apb(1'b1, 17'h00010, 8'hD4, 4'h1);
		chk("map_off", {ram_code_map, vector_in_ram}, 2'b00);
		vf(flash_ctl_pkg::VEC_WDT);
		chk("vec_flash", vector_addr, 16'hFFFC);
		$display("test remap done");
	endtask : t_remap

	task automatic t_prog;
		apb(1'b1, 17'h00000, 8'hA4, 4'h1);
		seq(8'hA0, 16'hE500, 8'h3F, 4'h1);
		chk("no_commit", n_ops, n0);
		apb(1'b1, 17'h00004, 8'hD5, 4'h1);
		seq(8'hA0, 16'hE500, 8'h3F, 4'h1);
		chk("prog_ops", n_ops, n0 + 1);
		chk("prog_op", last_op, {flash_ctl_pkg::OP_PROGRAM, 19'h1E500, 8'h3F});
		vf(flash_ctl_pkg::VEC_WDT);
		chk("fetch_bad", vector_fetch_invalid, 1'b1);
		apb(1'b0, 17'h1E500, 8'h00, 4'h1);
		a = rdat;
		apb(1'b0, 17'h1E500, 8'h00, 4'h1);
		chk("toggle", a[6] ^ rdat[6], 1'b1);
		poll();
		seq(8'h80, 16'hE000, 8'h30, 4'h1);
		chk("erase_ops", n_ops - n0, 32'd1);
		chk("erase_op", last_op[27:8], {1'b1, 19'h1E000});
		poll();
		seq(8'hA0, 16'hE501, 8'h3F, 4'h1);
		poll();
		seq(8'hA0, 16'hE501, 8'h3F, 4'hF);
		chk("wide", n_ops, n0);
		// Back-to-back writes land two cycles apart
		n0 = n_ops;
		apb(1'b1, 17'h1F555, 8'hAA, 4'h1);
		apb(1'b1, 17'h1FAAA, 8'h55, 4'h1);
		apb(1'b1, 17'h1F555, 8'hA0, 4'h1);
		apb(1'b1, 17'h1E503, 8'h3F, 4'h1);
		repeat (3) @(posedge pclk);
		chk("close", n_ops, n0);
		apb(1'b1, 17'h00000, 8'h40, 4'h1);
		apb(1'b1, 17'h00004, 8'hD5, 4'h1);
		seq(8'hA0, 16'hE502, 8'h3F, 4'h1);
		chk("disabled", n_ops, n0);
		$display("test program done");
	endtask : t_prog

	task automatic t_sysrst;
		n0 = n_rst;
		apb(1'b1, 17'h00008, 8'h11, 4'h1);
		apb(1'b1, 17'h00008, 8'h10, 4'h1);
		repeat (2) @(posedge pclk);
		chk("sysclk_reset", n_rst, n0 + 1);
		$display("test sysreset done");
	endtask : t_sysrst

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_remap();
		t_prog();
		t_sysrst();
		end_sim();
	end
endmodule : tb
